// ---- spm_pkg.sv ----
// shared constants, modes and carriers of the strap and pin function mux
package spm_pkg;

  // --------
  // register map (byte addresses)
  // --------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PRN_CTRL = 8'h00;   // printer control
  localparam logic [7:0] OFS_CFG3 = 8'h04;       // config_reg_three
  localparam logic [7:0] OFS_IR_CFG = 8'h08;     // ir_pin_config_reg
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0C;   // irq_control_reg
  localparam logic [7:0] OFS_MODE = 8'h10;       // active port mode
  localparam logic [7:0] OFS_STRAP = 8'h14;      // latched straps
  localparam logic [7:0] OFS_HS_A = 8'h18;       // handshake status a
  localparam logic [7:0] OFS_HS_B = 8'h1C;       // handshake status b
  localparam logic [7:0] OFS_MODEM_CTRL = 8'h20; // dtr / rts control

  // --------
  // field positions and reset values
  // --------
  localparam int BIT_DIR = 5;       // printer control direction bit
  localparam int BIT_BIDIR = 7;     // bidir_enable_bit in cfg 3
  localparam int BIT_IR_SEL = 0;    // uart b pins used for infrared
  localparam int BIT_IRQ_EN = 3;    // uart interrupt drive enable
  localparam int BIT_CTS = 4;       // handshake status fields
  localparam int BIT_DSR = 5;
  localparam int BIT_RI = 6;
  localparam int BIT_DCD = 7;
  localparam int BIT_DTR_A = 0;     // modem control fields
  localparam int BIT_RTS_A = 1;
  localparam int BIT_DTR_B = 2;
  localparam int BIT_RTS_B = 3;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h0F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // parallel port modes
  typedef enum logic [1:0] {
    SPM_PRINTER, SPM_EPP, SPM_ECP, SPM_ADAPTER
  } spm_mode_t;
  localparam spm_mode_t MODE_STRAP_HI = SPM_ECP;
  localparam spm_mode_t MODE_STRAP_LO = SPM_PRINTER;

  // pin levels coming from outside the clock domain
  typedef struct packed {
    logic mr;        // power_on_master_reset
    logic dir_force; // direction_force_in / ext_dma_ack_pin
    logic cts_a;
    logic cts_b;
    logic dsr_a;
    logic dsr_b;
    logic dcd_a;
    logic dcd_b;
    logic ri_a;
    logic ri_b;
    logic sin_b;     // uart_b_serial_in / ir_receive_in_one
    logic st_mode;   // port_mode_strap_hi on ext_dma_request_pin
    logic st_ua_hi;  // uart_a_serial_out pin
    logic st_ua_lo;  // uart_b_terminal_ready pin
    logic st_ub_hi;  // uart_b_serial_out pin
    logic st_ub_lo;  // uart_b_request_send pin
    logic st_prn_lo; // uart_a_terminal_ready pin
    logic st_prn_hi; // uart_a_request_send pin
  } spm_pins_t;
  // pull defaults; reset held asserted until the pin says otherwise
  localparam spm_pins_t PIN_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
    1'b0, 1'b0, 1'b1};

  // latched straps, laid out as read from the strap register
  typedef struct packed {
    logic mode_hi;
    logic [1:0] prn;
    logic [1:0] ub;
    logic [1:0] ua;
  } spm_strap_t;
  localparam spm_strap_t STRAP_RST = '{1'b0, 2'h1, 2'h2, 2'h2};

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } spm_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spm_axi_rsp_t;

  // whole state of the mux
  typedef struct packed {
    spm_pins_t s1;          // synchroniser stage 1
    spm_pins_t s2;          // stage 2
    spm_pins_t s3;          // stage 3
    spm_pins_t flt;         // agreed pin levels
    spm_strap_t strap;
    logic in_por;           // shared pins act as straps
    spm_mode_t mode;
    logic [7:0] prn_ctrl;
    logic [7:0] cfg3;
    logic [7:0] ir_cfg;
    logic [7:0] irq_ctrl;
    logic [7:0] modem_ctrl;
    logic prn_irq_d;        // previous printer request
    logic prn_out;
    logic prn_oe;
    logic par_oe;
    logic dack_adapter;
    logic dack_ecp;
    logic ua_tx;
    logic ub_tx;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spm_state_t;

endpackage : spm_pkg

// ---- spm_mux.sv ----
// strap capture, pin function mux and register slave of the i/o controller
// Operation
// R1: printer mode drives interrupt high on request
// R2: epp/ecp interrupt pulses low then releases
// R3: adapter dma request passes straight through
// R4: ecp mode drives port dma request
// R5: dma request pin straps port mode
// R6: direction force low makes data outputs
// R7: force high uses dir and bidir bits; printer mode only in this design, other modes keep outputs on
// R8: adapter mode takes pin as acknowledge
// R9: ecp mode takes pin as acknowledge
// R10: cts level shown in status bit 4
// R11: modem drives dsr low when ready
// R12: modem drives dcd low on carrier
// R13: modem drives ri low while ringing
// R14: uart b input becomes infrared receive
// R15: uart b output becomes infrared transmit
// R16: two straps set uart a address
// R17: two straps set uart b address
// R18: two straps set printer port address
// R19: dtr driven low after reset
// R20: rts driven low after reset
// R21: master reset is active high
// R22: uart interrupt floats until enabled
// R23: straps latched at reset end, then pins
// R24: interrupt low pulse lasts one cycle
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
module spm_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire spm_pkg::spm_axi_req_t axi_req,
  output spm_pkg::spm_axi_rsp_t axi_rsp,
  input wire spm_pkg::spm_pins_t pin_in,
  input wire logic adapter_dma_request,
  input wire logic ecp_dma_request,
  input wire logic prn_irq_req,
  input wire logic uart_irq_req,
  input wire logic uart_a_tx,
  input wire logic uart_b_tx,
  input wire logic ir_tx_data,
  output logic ext_dma_request_pin,
  output logic ext_dma_request_pin_oe,
  output logic printer_interrupt_out,
  output logic printer_interrupt_out_oe,
  output logic uart_irq_out,
  output logic uart_irq_oe,
  output logic par_data_oe,
  output logic adapter_dma_ack,
  output logic ecp_dma_ack,
  output logic uart_a_serial_out,
  output logic uart_a_serial_out_oe,
  output logic uart_b_serial_out,
  output logic uart_b_serial_out_oe,
  output logic uart_a_terminal_ready,
  output logic uart_a_terminal_ready_oe,
  output logic uart_b_terminal_ready,
  output logic uart_b_terminal_ready_oe,
  output logic uart_a_request_send,
  output logic uart_a_request_send_oe,
  output logic uart_b_request_send,
  output logic uart_b_request_send_oe,
  output logic uart_b_rx,
  output logic ir_receive_in_one,
  output spm_pkg::spm_mode_t active_mode,
  output spm_pkg::spm_strap_t strap
);
  import spm_pkg::*;

  // --------
  // helpers
  // --------

  // true for every offset that holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_PRN_CTRL, OFS_CFG3, OFS_IR_CFG, OFS_IRQ_CTRL, OFS_MODE,
      OFS_STRAP, OFS_HS_A, OFS_HS_B, OFS_MODEM_CTRL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // handshake status byte from agreed modem line levels
  function automatic logic [7:0] hs_byte(input logic cts,
    input logic dsr, input logic ri, input logic dcd);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_CTS] = cts;
    b[BIT_DSR] = dsr;
    b[BIT_RI] = ri;
    b[BIT_DCD] = dcd;
    hs_byte = b;
  endfunction : hs_byte

  // --------
  // state
  // --------
  spm_state_t st;       // registered state
  spm_state_t next_st;  // next state
  logic [31:0] rd_word; // read mux result
  logic ir_sel;         // uart b pins in infrared role
  logic pulse_mode;     // epp or ecp interrupt style

  assign ir_sel = st.ir_cfg[BIT_IR_SEL];
  assign pulse_mode = (st.mode == SPM_EPP) || (st.mode == SPM_ECP);

  // read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    case (axi_req.araddr)
      OFS_PRN_CTRL: rd_word[7:0] = st.prn_ctrl;
      OFS_CFG3: rd_word[7:0] = st.cfg3;
      OFS_IR_CFG: rd_word[7:0] = st.ir_cfg;
      OFS_IRQ_CTRL: rd_word[7:0] = st.irq_ctrl;
      OFS_MODE: rd_word[1:0] = st.mode;
      OFS_STRAP: rd_word[6:0] = st.strap;
      // R10: cts shown in bit 4
      OFS_HS_A: rd_word[7:0] = hs_byte(st.flt.cts_a, st.flt.dsr_a,
                                       st.flt.ri_a, st.flt.dcd_a);
      OFS_HS_B: rd_word[7:0] = hs_byte(st.flt.cts_b, st.flt.dsr_b,
                                       st.flt.ri_b, st.flt.dcd_b);
      OFS_MODEM_CTRL: rd_word[7:0] = st.modem_ctrl;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // --------
  // next state
  // --------
  always_comb begin
    next_st = st;

    // three-stage synchroniser; a level counts once stages 2 and 3 agree
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.flt = (st.flt & (st.s2 ^ st.s3)) | (st.s3 & ~(st.s2 ^ st.s3));

    // R21: master reset held high keeps the strap phase
    if (st.flt.mr) begin
      next_st.in_por = 1'b1;
      // R5: port mode strap
      next_st.strap.mode_hi = st.flt.st_mode;
      // R16: uart a address straps
      next_st.strap.ua = {st.flt.st_ua_hi, st.flt.st_ua_lo};
      // R17: uart b address straps
      next_st.strap.ub = {st.flt.st_ub_hi, st.flt.st_ub_lo};
      // R18: printer address straps
      next_st.strap.prn = {st.flt.st_prn_hi, st.flt.st_prn_lo};
    end else if (st.in_por) begin
      // R23: straps frozen, pins handed over, mode taken from strap
      next_st.in_por = 1'b0;
      next_st.mode = st.strap.mode_hi ? MODE_STRAP_HI : MODE_STRAP_LO;
    end

    // printer interrupt line
    next_st.prn_irq_d = prn_irq_req;
    if (st.mode == SPM_PRINTER) begin
      // R1: level drive, high while requesting
      next_st.prn_out = prn_irq_req;
      next_st.prn_oe = 1'b1;
    end else if (pulse_mode) begin
      // R2: low pulse on a new request, else released
      // R24: pulse one cycle wide
      next_st.prn_out = 1'b0;
      next_st.prn_oe = prn_irq_req && !st.prn_irq_d;
    end else begin
      // adapter mode leaves the line to its pull-up
      next_st.prn_out = 1'b0;
      next_st.prn_oe = 1'b0;
    end

    // R6: force low makes the data lines outputs
    // R7: in printer mode force high follows dir and bidir bits; other modes keep outputs on
    next_st.par_oe = (st.mode != SPM_PRINTER) || !st.flt.dir_force ||
      !(st.prn_ctrl[BIT_DIR] && st.cfg3[BIT_BIDIR]);

    // R8: adapter acknowledge, active low pin
    next_st.dack_adapter = (st.mode == SPM_ADAPTER) && !st.flt.dir_force;
    // R9: ecp acknowledge, active low pin
    next_st.dack_ecp = (st.mode == SPM_ECP) && !st.flt.dir_force;

    // serial data toward the pins
    next_st.ua_tx = uart_a_tx;
    // R15: infrared transmit takes the uart b output
    next_st.ub_tx = ir_sel ? ir_tx_data : uart_b_tx;

    // write address and data taken in either order
    if (axi_req.awvalid && !st.aw_full) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_full) begin
      next_st.w_full = 1'b1;
      next_st.w_data = axi_req.wdata[7:0];
      next_st.w_en = axi_req.wstrb[0];
    end
    // write response leaves once taken
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    // both halves held: perform the write
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st.w_en) begin
        case (st.aw_addr)
          OFS_PRN_CTRL: next_st.prn_ctrl = st.w_data;
          OFS_CFG3: next_st.cfg3 = st.w_data;
          OFS_IR_CFG: next_st.ir_cfg = st.w_data;
          OFS_IRQ_CTRL: next_st.irq_ctrl = st.w_data;
          OFS_MODE: next_st.mode = spm_mode_t'(st.w_data[1:0]);
          OFS_MODEM_CTRL: next_st.modem_ctrl = st.w_data;
          default: next_st.bresp = next_st.bresp;
        endcase
      end
    end

    // read: answer one cycle after the address is taken
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // synchronous bus reset loads constants only
    if (!aresetn) begin
      next_st = '0;
      next_st.s1 = PIN_RST;
      next_st.s2 = PIN_RST;
      next_st.s3 = PIN_RST;
      next_st.flt = PIN_RST;
      next_st.strap = STRAP_RST;
      next_st.in_por = 1'b1;
      next_st.mode = MODE_STRAP_LO;
      // R19: dtr asserted once reset ends
      // R20: rts asserted once reset ends
      next_st.modem_ctrl = RST_MODEM_CTRL;
    end
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // --------
  // bus answers
  // --------
  always_comb begin
    axi_rsp.awready = !st.aw_full;
    axi_rsp.wready = !st.w_full;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = st.rdata;
    axi_rsp.rresp = st.rresp;
  end

  // --------
  // pins
  // --------

  // R3: adapter request passes unlatched
  // R4: ecp request otherwise; floats in strap phase for R5
  assign ext_dma_request_pin = (st.mode == SPM_ADAPTER) ?
    adapter_dma_request : ecp_dma_request;
  assign ext_dma_request_pin_oe = !st.in_por &&
    ((st.mode == SPM_ADAPTER) || (st.mode == SPM_ECP));

  // printer interrupt from flops
  assign printer_interrupt_out = st.prn_out;
  assign printer_interrupt_out_oe = st.prn_oe;

  // R22: uart interrupt floats until enabled
  assign uart_irq_out = uart_irq_req;
  assign uart_irq_oe = !st.in_por && st.irq_ctrl[BIT_IRQ_EN];

  // parallel direction and acknowledges
  assign par_data_oe = st.par_oe;
  assign adapter_dma_ack = st.dack_adapter;
  assign ecp_dma_ack = st.dack_ecp;

  // R23: shared strap pins driven only after the strap phase
  assign uart_a_serial_out = st.ua_tx;
  assign uart_a_serial_out_oe = !st.in_por;
  assign uart_b_serial_out = st.ub_tx;
  assign uart_b_serial_out_oe = !st.in_por;
  // R19: dtr low while asserted
  assign uart_a_terminal_ready = !st.modem_ctrl[BIT_DTR_A];
  assign uart_a_terminal_ready_oe = !st.in_por;
  assign uart_b_terminal_ready = !st.modem_ctrl[BIT_DTR_B];
  assign uart_b_terminal_ready_oe = !st.in_por;
  // R20: rts low while asserted
  assign uart_a_request_send = !st.modem_ctrl[BIT_RTS_A];
  assign uart_a_request_send_oe = !st.in_por;
  assign uart_b_request_send = !st.modem_ctrl[BIT_RTS_B];
  assign uart_b_request_send_oe = !st.in_por;

  // R14: uart b input routed to infrared receive; idle levels otherwise
  assign uart_b_rx = ir_sel ? 1'b1 : st.flt.sin_b;
  assign ir_receive_in_one = ir_sel ? st.flt.sin_b : 1'b0;

  // strap results and mode for decoders elsewhere
  assign active_mode = st.mode;
  assign strap = st.strap;

endmodule : spm_mux

// ---- spm_far.sv ----
// far-side model: modems, jumpers and pulls behind the shared pins
module spm_far (
  input wire spm_pkg::spm_pins_t far,
  input wire logic ext_dma_request_pin,
  input wire logic ext_dma_request_pin_oe,
  input wire logic uart_a_serial_out,
  input wire logic uart_a_serial_out_oe,
  input wire logic uart_b_serial_out,
  input wire logic uart_b_serial_out_oe,
  input wire logic uart_a_terminal_ready,
  input wire logic uart_a_terminal_ready_oe,
  input wire logic uart_b_terminal_ready,
  input wire logic uart_b_terminal_ready_oe,
  input wire logic uart_a_request_send,
  input wire logic uart_a_request_send_oe,
  input wire logic uart_b_request_send,
  input wire logic uart_b_request_send_oe,
  output spm_pkg::spm_pins_t pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  // --------
  // pin levels
  // --------
  // shared pins show the driver when enabled, else jumper or pull level
  always_comb begin
    pin_in = far;
    if (ext_dma_request_pin_oe) pin_in.st_mode = ext_dma_request_pin;
    if (uart_a_serial_out_oe) pin_in.st_ua_hi = uart_a_serial_out;
    if (uart_b_terminal_ready_oe) pin_in.st_ua_lo = uart_b_terminal_ready;
    if (uart_b_serial_out_oe) pin_in.st_ub_hi = uart_b_serial_out;
    if (uart_b_request_send_oe) pin_in.st_ub_lo = uart_b_request_send;
    if (uart_a_terminal_ready_oe) pin_in.st_prn_lo = uart_a_terminal_ready;
    if (uart_a_request_send_oe) pin_in.st_prn_hi = uart_a_request_send;
  end
endmodule : spm_far

// ---- spm_mux_checker.sv ----
// concurrent checks on the ports of the pin function mux
module spm_mux_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire spm_pkg::spm_pins_t pin_in,
  input wire logic adapter_dma_request,
  input wire logic ecp_dma_request,
  input wire logic prn_irq_req,
  input wire logic uart_irq_req,
  input wire logic ext_dma_request_pin,
  input wire logic ext_dma_request_pin_oe,
  input wire logic printer_interrupt_out,
  input wire logic printer_interrupt_out_oe,
  input wire logic uart_irq_out,
  input wire logic uart_irq_oe,
  input wire logic par_data_oe,
  input wire logic adapter_dma_ack,
  input wire logic ecp_dma_ack,
  input wire logic uart_a_serial_out_oe,
  input wire logic uart_a_terminal_ready,
  input wire logic uart_a_terminal_ready_oe,
  input wire logic uart_b_terminal_ready,
  input wire logic uart_a_request_send,
  input wire logic uart_b_request_send,
  input wire spm_pkg::spm_mode_t active_mode,
  input wire spm_pkg::spm_strap_t strap
);
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  // --------
  // sequences and properties
  // --------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pins driven, mode held, force pin held low long enough to filter
  sequence s_low_in(spm_mode_t m);
    (uart_a_serial_out_oe && active_mode == m && !pin_in.dir_force) [*8];
  endsequence
  // one-cycle low drive then release
  sequence s_pulse;
    !printer_interrupt_out ##1 !printer_interrupt_out_oe;
  endsequence
  property p_pulse;
    (active_mode inside {SPM_EPP, SPM_ECP}) &&
      $rose(printer_interrupt_out_oe) |-> s_pulse;
  endproperty
  property p_prn;
    active_mode == SPM_PRINTER && $past(active_mode) == SPM_PRINTER &&
      uart_a_serial_out_oe && $past(uart_a_serial_out_oe) |->
      printer_interrupt_out_oe && printer_interrupt_out == $past(prn_irq_req);
  endproperty
  property p_pass_ad;
    active_mode == SPM_ADAPTER && ext_dma_request_pin_oe |->
      ext_dma_request_pin == adapter_dma_request;
  endproperty
  property p_pass_ecp;
    active_mode == SPM_ECP && ext_dma_request_pin_oe |->
      ext_dma_request_pin == ecp_dma_request;
  endproperty
  property p_ack_ecp;
    s_low_in(SPM_ECP) |-> ecp_dma_ack;
  endproperty
  property p_ack_ad;
    s_low_in(SPM_ADAPTER) |-> adapter_dma_ack;
  endproperty
  property p_force;
    s_low_in(SPM_PRINTER) |-> par_data_oe;
  endproperty
  property p_mode_load;
    $rose(uart_a_serial_out_oe) |->
      active_mode == (strap.mode_hi ? SPM_ECP : SPM_PRINTER);
  endproperty
  property p_strap;
    uart_a_serial_out_oe && $past(uart_a_serial_out_oe) |-> $stable(strap);
  endproperty
  property p_irq;
    uart_irq_oe |-> uart_a_serial_out_oe && uart_irq_out == uart_irq_req;
  endproperty
  property p_dtr;
    $rose(uart_a_terminal_ready_oe) |-> !uart_a_terminal_ready &&
      !uart_b_terminal_ready && !uart_a_request_send && !uart_b_request_send;
  endproperty
  // --------
  // assertions
  // --------
  a_pulse: assert property (p_pulse)
    else $error("interrupt pulse not one low cycle");
  a_prn: assert property (p_prn)
    else $error("printer interrupt not driven from request");
  a_pass_ad: assert property (p_pass_ad)
    else $error("adapter request not passed");
  a_pass_ecp: assert property (p_pass_ecp)
    else $error("port request not passed");
  a_ack_ecp: assert property (p_ack_ecp)
    else $error("port acknowledge missing");
  a_ack_ad: assert property (p_ack_ad)
    else $error("adapter acknowledge missing");
  a_force: assert property (p_force)
    else $error("data lines not outputs under force");
  a_mode_load: assert property (p_mode_load)
    else $error("mode not loaded from strap");
  a_strap: assert property (p_strap)
    else $error("strap changed after release");
  a_irq: assert property (p_irq)
    else $error("uart interrupt driven while disabled");
  a_dtr: assert property (p_dtr)
    else $error("modem outputs not low after reset");
endmodule : spm_mux_checker

bind spm_mux spm_mux_checker u_chk (.aclk, .aresetn, .pin_in,
  .adapter_dma_request, .ecp_dma_request, .prn_irq_req, .uart_irq_req,
  .ext_dma_request_pin, .ext_dma_request_pin_oe, .printer_interrupt_out,
  .printer_interrupt_out_oe, .uart_irq_out, .uart_irq_oe, .par_data_oe,
  .adapter_dma_ack, .ecp_dma_ack, .uart_a_serial_out_oe,
  .uart_a_terminal_ready, .uart_a_terminal_ready_oe, .uart_b_terminal_ready,
  .uart_a_request_send, .uart_b_request_send, .active_mode, .strap);

// ---- spm_mux_test.sv ----
// register-level testbench of the strap and pin function mux
module spm_mux_test;
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  logic aclk, aresetn, adapter_dma_request, ecp_dma_request, prn_irq_req;
  logic uart_irq_req, uart_a_tx, uart_b_tx, ir_tx_data;
  logic ext_dma_request_pin, ext_dma_request_pin_oe, printer_interrupt_out;
  logic printer_interrupt_out_oe, uart_irq_out, uart_irq_oe, par_data_oe;
  logic adapter_dma_ack, ecp_dma_ack, uart_b_rx, ir_receive_in_one;
  logic uart_a_serial_out, uart_a_serial_out_oe, uart_b_serial_out;
  logic uart_b_serial_out_oe, uart_a_terminal_ready, uart_a_terminal_ready_oe;
  logic uart_b_terminal_ready, uart_b_terminal_ready_oe, uart_a_request_send;
  logic uart_a_request_send_oe, uart_b_request_send, uart_b_request_send_oe;
  spm_axi_req_t axi_req; // bus master side
  spm_axi_rsp_t axi_rsp;
  spm_pins_t far, pin_in; // jumpers and modem levels, pin view
  spm_mode_t active_mode;
  spm_strap_t strap;
  int fail_count, num_checks, n, k;
  logic [31:0] rd;
  logic [1:0] rs;
  // --------
  // design, far side and clock
  // --------
  spm_mux dut (.aclk, .aresetn, .axi_req, .axi_rsp, .pin_in,
    .adapter_dma_request, .ecp_dma_request, .prn_irq_req, .uart_irq_req,
    .uart_a_tx, .uart_b_tx, .ir_tx_data, .ext_dma_request_pin,
    .ext_dma_request_pin_oe, .printer_interrupt_out, .printer_interrupt_out_oe,
    .uart_irq_out, .uart_irq_oe, .par_data_oe, .adapter_dma_ack, .ecp_dma_ack,
    .uart_a_serial_out, .uart_a_serial_out_oe, .uart_b_serial_out,
    .uart_b_serial_out_oe, .uart_a_terminal_ready, .uart_a_terminal_ready_oe,
    .uart_b_terminal_ready, .uart_b_terminal_ready_oe, .uart_a_request_send,
    .uart_a_request_send_oe, .uart_b_request_send, .uart_b_request_send_oe,
    .uart_b_rx, .ir_receive_in_one, .active_mode, .strap);
  spm_far u_far (.far, .ext_dma_request_pin, .ext_dma_request_pin_oe,
    .uart_a_serial_out, .uart_a_serial_out_oe, .uart_b_serial_out,
    .uart_b_serial_out_oe, .uart_a_terminal_ready, .uart_a_terminal_ready_oe,
    .uart_b_terminal_ready, .uart_b_terminal_ready_oe, .uart_a_request_send,
    .uart_a_request_send_oe, .uart_b_request_send, .uart_b_request_send_oe,
    .pin_in);
  // free-running 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // --------
  // tasks
  // --------
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc
  // a wait that ran out ends the run
  task automatic hang();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop();
  endtask : hang
  // one write; address and data released as each is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    if (i == 40) hang();
    rs = axi_rsp.bresp;
  endtask : axw
  // one read; data and response taken at the rvalid edge
  task automatic axr(input logic [7:0] a);
    int i;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) break;
    end
    if (i == 40) hang();
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
  endtask : axr
  // one new interrupt request; exactly one low pulse expected
  task automatic pulses();
    k = 0;
    prn_irq_req <= 1'b1;
    repeat (10) begin
      @(posedge aclk);
      if (printer_interrupt_out_oe) begin
        k++;
        chk(printer_interrupt_out, 0);
      end
    end
    chk(k, 1);
    prn_irq_req <= 1'b0;
  endtask : pulses
  // --------
  // main sequence
  // --------
  initial begin
    {aresetn, adapter_dma_request, ecp_dma_request, prn_irq_req} = '0;
    {uart_irq_req, uart_a_tx, uart_b_tx, ir_tx_data} = '0;
    axi_req = '0;
    // response channels always ready
    {axi_req.bready, axi_req.rready} = 2'b11;
    fail_count = 0;
    num_checks = 0;
    // jumpers: mode high, uart a 01, uart b 11, printer 11
    far = PIN_RST;
    far.st_mode = 1'b1;
    far.st_ua_hi = 1'b0;
    far.st_ua_lo = 1'b1;
    far.st_ub_lo = 1'b1;
    far.st_prn_lo = 1'b1;
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    far.mr <= 1'b0;
    for (n = 0; n < 20 && !uart_a_serial_out_oe; n++) cyc(1);
    if (n == 20) hang();
    chk({25'h0, strap}, 32'h7D);
    chk(active_mode, SPM_ECP);
    chk({uart_a_terminal_ready, uart_b_terminal_ready, uart_a_request_send,
      uart_b_request_send}, 0);
    axr(OFS_STRAP);
    chk(rd, 32'h7D);
    chk(uart_irq_oe, 0);
    uart_irq_req <= 1'b1;
    axw(OFS_IRQ_CTRL, 32'h8);
    chk(rs, RESP_OKAY);
    cyc(1);
    chk({uart_irq_oe, uart_irq_out}, 2'b11);
    ecp_dma_request <= 1'b1;
    cyc(1);
    chk({ext_dma_request_pin_oe, ext_dma_request_pin}, 2'b11);
    far.dir_force <= 1'b0;
    cyc(8);
    chk(ecp_dma_ack, 1);
    far.dir_force <= 1'b1;
    pulses();
    axw(OFS_MODE, 32'h1);
    pulses();
    axw(OFS_MODE, 32'h3);
    adapter_dma_request <= 1'b1;
    cyc(1);
    chk({ext_dma_request_pin_oe, ext_dma_request_pin}, 2'b11);
    adapter_dma_request <= 1'b0;
    far.dir_force <= 1'b0;
    cyc(1);
    chk({ext_dma_request_pin_oe, ext_dma_request_pin}, 2'b10);
    cyc(7);
    chk(adapter_dma_ack, 1);
    axw(OFS_MODE, 32'h0);
    prn_irq_req <= 1'b1;
    cyc(3);
    chk({printer_interrupt_out_oe, printer_interrupt_out}, 2'b11);
    // direction bits under force high, then all set under force low
    for (n = 0; n < 5; n++) begin
      far.dir_force <= (n < 4);
      axw(OFS_PRN_CTRL, (n == 4 || n[0]) ? 32'h20 : 32'h0);
      axw(OFS_CFG3, (n == 4 || n[1]) ? 32'h80 : 32'h0);
      cyc(8);
      chk(par_data_oe, n != 3);
    end
    {far.cts_a, far.dsr_a, far.dcd_a, far.ri_a} <= 4'h0;
    ir_tx_data <= 1'b1;
    cyc(8);
    axr(OFS_HS_A);
    chk(rd, 32'h0);
    axr(OFS_HS_B);
    chk(rd, 32'hF0);
    chk({ir_receive_in_one, uart_b_rx, uart_b_serial_out}, 3'b010);
    axw(OFS_IR_CFG, 32'h1);
    far.sin_b <= 1'b0;
    uart_a_tx <= 1'b1;
    cyc(8);
    chk({ir_receive_in_one, uart_b_rx, uart_b_serial_out,
      uart_a_serial_out}, 4'b0111);
    axr(8'h40);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h40, 32'h1);
    chk(rs, RESP_SLVERR);
    report_and_stop();
  end
endmodule : spm_mux_test
